// ---- rtl/fwps_core.sv ----
/*
 * write-protect and status control of a serial flash: latch, busy,
 * block protect, status protect and lock-down, power-down, power-up delay.
 * assumes a decoder on ref_clk presents each whole instruction as one
 * cmd pulse; wp_n_pin and sclk_pin are asynchronous pins.
 */
// Operation
// - while power-on reset holds, all operations stop and nothing is recognised.
// - after reset, write enable, program, erase, status write refused for delay.
// - power-up leaves the write-enable latch at zero.
// - program, erase and status write need the latch set first.
// - write enable sets the latch at status bit one.
// - write disable or finished program, erase, status write clears latch.
// - busy at bit zero is one during an operation, zero after.
// - while busy only read status and suspend are taken.
// - in power-down only release power-down is taken.
// - four block-protect bits pick protected part; default nothing protected. here any non-zero value protects the whole array.
// - top/bottom zero protects from top, one from bottom; default zero. here it only drives array_write_top and plays no part in the protection check.
// - complement bit, default zero, inverts the chosen protection.
// - lock and protect zero: pin ignored, status writes need only latch.
// - lock zero, protect one, pin low: status writes blocked.
// - lock zero, protect one, pin high: status writes accepted with latch.
// - lock one refuses status writes until next power cycle.
// - permanent lock only after the two-byte prefix; then writes refused forever. here only status writes are refused, and rst clears the lock.
// - pin gates status writes only in standard and dual mode.
// - lock bit returns to zero after a power cycle.
`timescale 1ns/1ns
module fwps_core
   import fwps_pkg::*;
#(
   parameter int TPU_CYCLES = FWPS_TPU_CYC,
   parameter int OP_CYCLES  = FWPS_OP_CYC
) (
   // clock and power-on reset
   input  wire logic         ref_clk,
   input  wire logic         rst,
   // pins
   input  wire logic         wp_n_pin,
   input  wire logic         sclk_pin,
   // decoded instruction
   input  wire fwps_cmd_t    cmd,
   input  wire fwps_ifmode_t if_mode,
   // status read-back and answers
   output logic [7:0]        status_one,
   output logic [7:0]        status_two,
   output logic              cmd_taken,
   output logic              cmd_refused,
   // array write gate, power-down, lock and serial clock edge
   output logic              array_write_go,
   output logic              array_write_top,
   output logic              power_down,
   output logic              otp_locked,
   output logic              sclk_rise
);

   if (TPU_CYCLES < 1 || OP_CYCLES < 1) begin : g_bad_cycles
      $error("fwps_core: cycle counts must be at least one");
   end

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [1:0] wp_sync_q;
   logic [2:0] sclk_sync_q;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wp_sync_q   <= 2'b00;
         sclk_sync_q <= 3'b000;
      end else begin
         wp_sync_q   <= {wp_sync_q[0], wp_n_pin};
         sclk_sync_q <= {sclk_sync_q[1:0], sclk_pin};
      end
   end

   logic wp_n_s;
   assign wp_n_s = wp_sync_q[1];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) sclk_rise <= 1'b0;
      else     sclk_rise <= sclk_sync_q[1] & ~sclk_sync_q[2];
   end

   // ************************************************************
   // power-up write delay
   // ************************************************************
   localparam int TPW = $clog2(TPU_CYCLES + 1);
   logic [TPW-1:0] pu_cnt_q;
   logic           pu_done;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         pu_cnt_q <= '0;
      else if (!pu_done)
         pu_cnt_q <= pu_cnt_q + TPW'(1);
   end
   assign pu_done = (pu_cnt_q == TPW'(TPU_CYCLES));

   // ************************************************************
   // instruction classes
   // ************************************************************
   logic [7:0] op;
   logic       is_wren, is_wrdi, is_wrsr, is_arr, is_sec, is_rdsr, is_susp;
   assign op      = cmd.opcode;
   assign is_wren = op == FWPS_OP_WREN;
   assign is_wrdi = op == FWPS_OP_WRDI;
   assign is_wrsr = op == FWPS_OP_WRSR;
   assign is_arr  = op == FWPS_OP_PP || op == FWPS_OP_QPP || op == FWPS_OP_SE
                 || op == FWPS_OP_BE32 || op == FWPS_OP_BE64 || op == FWPS_OP_CE;
   assign is_sec  = op == FWPS_OP_SECERS || op == FWPS_OP_SECPRG;
   assign is_rdsr = op == FWPS_OP_RDSR1 || op == FWPS_OP_RDSR2;
   assign is_susp = op == FWPS_OP_SUSPEND;

   // ************************************************************
   // state and gating
   // ************************************************************
   logic       wel_q, busy_q, pd_q, srl_q, otp_q, pfx_a_q, pfx_ok_q;
   logic       srp_q, tb_q, cmp_q;
   logic [3:0] bp_q;
   localparam int OCW = $clog2(OP_CYCLES + 1);
   logic [OCW-1:0] op_cnt_q;
   logic       op_is_sr_q, op_done;
   logic [7:0] sr_new_q;
   logic       sr_new_cmp_q;

   logic seen, wr_class, allowed, sr_ok, wp_counts, arr_prot, start;

   // nothing recognised during power-down except release, nor while busy except read status and suspend
   assign seen = cmd.valid
              && (!pd_q || op == FWPS_OP_RELPD)
              && (!busy_q || is_rdsr || is_susp);

   assign wr_class  = is_wren || is_wrsr || is_arr || is_sec;
   assign wp_counts = (if_mode == FWPS_IF_SPI || if_mode == FWPS_IF_DUAL);

   always_comb begin
      sr_ok = 1'b1;
      if (otp_q || srl_q)
         sr_ok = 1'b0;
      else if (srp_q && wp_counts && !wp_n_s)
         sr_ok = 1'b0;
   end

   // protected-range choice: any non-zero bp protects the whole array, then complement; top/bottom unused
   assign arr_prot = ((bp_q != FWPS_BP_RST)) ^ cmp_q;

   always_comb begin
      allowed = 1'b1;
      if (wr_class && !pu_done)
         allowed = 1'b0;
      else if ((is_wrsr || is_arr || is_sec) && !wel_q)
         allowed = 1'b0;
      else if (is_wrsr && !sr_ok)
         allowed = 1'b0;
      else if (is_arr && arr_prot)
         allowed = 1'b0;
   end

   assign start = seen && allowed && (is_wrsr || is_arr || is_sec);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_taken   <= 1'b0;
         cmd_refused <= 1'b0;
      end else begin
         cmd_taken   <= seen && allowed;
         cmd_refused <= cmd.valid && !(seen && allowed);
      end
   end

   // ************************************************************
   // operation timer and busy
   // ************************************************************
   assign op_done = busy_q && (op_cnt_q == OCW'(1));

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_q     <= 1'b0;
         op_cnt_q   <= '0;
         op_is_sr_q <= 1'b0;
      end else if (start) begin
         busy_q     <= 1'b1;
         op_cnt_q   <= OCW'(OP_CYCLES);
         op_is_sr_q <= is_wrsr;
      end else if (busy_q) begin
         op_cnt_q <= op_cnt_q - OCW'(1);
         if (op_done)
            busy_q <= 1'b0;
      end
   end

   // ************************************************************
   // write-enable latch
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         wel_q <= 1'b0;
      else if (seen && allowed && is_wren)
         wel_q <= 1'b1;
      else if ((seen && is_wrdi) || op_done)
         wel_q <= 1'b0;
   end

   // ************************************************************
   // power-down
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         pd_q <= 1'b0;
      else if (seen && op == FWPS_OP_PDOWN)
         pd_q <= 1'b1;
      else if (seen && op == FWPS_OP_RELPD)
         pd_q <= 1'b0;
   end

   // ************************************************************
   // one-time-lock prefix tracking
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pfx_a_q  <= 1'b0;
         pfx_ok_q <= 1'b0;
      end else if (seen) begin
         pfx_a_q  <= op == FWPS_OP_PFX_A;
         pfx_ok_q <= pfx_a_q && op == FWPS_OP_PFX_B
                  || pfx_ok_q && !is_wrsr && !is_arr;
      end
   end

   // ************************************************************
   // status register contents
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sr_new_q     <= 8'h00;
         sr_new_cmp_q <= 1'b0;
      end else if (start && is_wrsr) begin
         sr_new_q     <= cmd.data1;
         sr_new_cmp_q <= cmd.data2[6];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bp_q  <= FWPS_BP_RST;
         tb_q  <= FWPS_TB_RST;
         cmp_q <= FWPS_CMP_RST;
         srp_q <= FWPS_SRP_RST;
         srl_q <= 1'b0;
      end else if (op_done && op_is_sr_q) begin
         bp_q  <= sr_new_q[FWPS_BIT_BP_LO +: 4];
         tb_q  <= sr_new_q[FWPS_BIT_TB];
         cmp_q <= sr_new_cmp_q;
         srp_q <= sr_new_q[FWPS_BIT_SRP];
         srl_q <= sr_new_q[0];
      end
   end

   // permanent lock survives the power-on reset of this logic only in concept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst)
         otp_q <= 1'b0;
      else if (start && is_wrsr && pfx_ok_q && cmd.data1[0])
         otp_q <= 1'b1;
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         status_one      <= 8'h00;
         status_two      <= 8'h00;
         array_write_go  <= 1'b0;
         array_write_top <= 1'b0;
         power_down      <= 1'b0;
         otp_locked      <= 1'b0;
      end else begin
         status_one      <= {srp_q, tb_q, bp_q, wel_q, busy_q};
         status_two      <= {1'b0, cmp_q, 5'h00, srl_q};
         array_write_go  <= start && is_arr;
         array_write_top <= ~tb_q;
         power_down      <= pd_q;
         otp_locked      <= otp_q;
      end
   end

endmodule : fwps_core

// ---- rtl/fwps_pkg.sv ----
/*
 * package of the flash write-protect and status block: instruction codes,
 * status field positions, reset values, power-up delay.
 * assumes a 50 MHz ref_clk.
 */
package fwps_pkg;

   // ************************************************************
   // instruction codes
   // ************************************************************
   localparam logic [7:0] FWPS_OP_WREN    = 8'h06;
   localparam logic [7:0] FWPS_OP_WRDI    = 8'h04;
   localparam logic [7:0] FWPS_OP_RDSR1   = 8'h05;
   localparam logic [7:0] FWPS_OP_RDSR2   = 8'h35;
   localparam logic [7:0] FWPS_OP_WRSR    = 8'h01;
   localparam logic [7:0] FWPS_OP_PP      = 8'h02;
   localparam logic [7:0] FWPS_OP_QPP     = 8'h32;
   localparam logic [7:0] FWPS_OP_SE      = 8'h20;
   localparam logic [7:0] FWPS_OP_BE32    = 8'h52;
   localparam logic [7:0] FWPS_OP_BE64    = 8'hD8;
   localparam logic [7:0] FWPS_OP_CE      = 8'hC7;
   localparam logic [7:0] FWPS_OP_SECERS  = 8'h44;
   localparam logic [7:0] FWPS_OP_SECPRG  = 8'h42;
   localparam logic [7:0] FWPS_OP_SUSPEND = 8'h75;
   localparam logic [7:0] FWPS_OP_PDOWN   = 8'hB9;
   localparam logic [7:0] FWPS_OP_RELPD   = 8'hAB;
   localparam logic [7:0] FWPS_OP_PFX_A   = 8'hAA;
   localparam logic [7:0] FWPS_OP_PFX_B   = 8'h55;

   // ************************************************************
   // status field positions and reset values
   // ************************************************************
   localparam int         FWPS_BIT_BUSY   = 0;
   localparam int         FWPS_BIT_WEL    = 1;
   localparam int         FWPS_BIT_BP_LO  = 2;
   localparam int         FWPS_BIT_TB     = 6;
   localparam int         FWPS_BIT_SRP    = 7;
   localparam logic [3:0] FWPS_BP_RST     = 4'h0;
   localparam logic       FWPS_TB_RST     = 1'b0;
   localparam logic       FWPS_CMP_RST    = 1'b0;
   localparam logic       FWPS_SRP_RST    = 1'b0;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int FWPS_CLK_MHZ     = 50;
   localparam int FWPS_TPU_US      = 1;
   localparam int FWPS_TPU_CYC     = FWPS_TPU_US * FWPS_CLK_MHZ;
   localparam int FWPS_OP_CYC      = 16;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {FWPS_IF_SPI, FWPS_IF_DUAL, FWPS_IF_QUAD, FWPS_IF_QPI} fwps_ifmode_t;

   typedef struct packed {
      logic       status_protect_bit;
      logic       top_bottom_select;
      logic [3:0] block_protect_level;
      logic       write_enable_latch;
      logic       busy;
   } fwps_status_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] opcode;
      logic [7:0] data1;
      logic [7:0] data2;
   } fwps_cmd_t;

endpackage : fwps_pkg

// ---- sim/fwps_core_properties.sv ----
/* port checker of fwps_core: answers, latch, busy, protection gating.
   assumes it is bound onto fwps_core, one ref_clk domain. */
`timescale 1ns/1ns
module fwps_core_chk
   import fwps_pkg::*;
#(
   parameter int TPU_CYCLES = 50,
   parameter int OP_CYCLES  = 16
) (
   // clock and reset
   input wire logic         ref_clk,
   input wire logic         rst,
   // inputs
   input wire logic         wp_n_pin,
   input wire fwps_cmd_t    cmd,
   input wire fwps_ifmode_t if_mode,
   // outputs
   input wire logic [7:0]   status_one,
   input wire logic [7:0]   status_two,
   input wire logic         cmd_taken,
   input wire logic         cmd_refused,
   input wire logic         power_down
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   int   up_cnt;
   int   busy_cnt;
   logic wr_op;
   logic rd_op;
   assign wr_op = cmd.valid && (cmd.opcode inside {FWPS_OP_PP, FWPS_OP_SE, FWPS_OP_CE, FWPS_OP_WRSR});
   assign rd_op = cmd.opcode inside {FWPS_OP_RDSR1, FWPS_OP_RDSR2, FWPS_OP_SUSPEND};
   // cycles since reset release, saturating
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) up_cnt <= 0;
      else if (up_cnt < 1000) up_cnt <= up_cnt + 1;
   end
   // length of the current busy run
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) busy_cnt <= 0;
      else busy_cnt <= status_one[0] ? busy_cnt + 1 : 0;
   end
   property p_reset_quiet; disable iff (1'b0) rst |-> status_one == 8'h00 && !cmd_taken && !cmd_refused; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
   property p_delay; cmd.valid && cmd.opcode == FWPS_OP_WREN && up_cnt < TPU_CYCLES - 2 |=> cmd_refused; endproperty
   a_delay: assert property (p_delay) else $error("write enable taken in power-up delay");
   property p_wel_zero; $past(rst) |-> status_one[1] == 1'b0; endproperty
   a_wel_zero: assert property (p_wel_zero) else $error("latch set after reset");
   property p_need_wel; wr_op ##1 !status_one[1] |-> cmd_refused; endproperty
   a_need_wel: assert property (p_need_wel) else $error("write taken without latch");
   property p_wel_set; cmd.valid && cmd.opcode == FWPS_OP_WREN ##1 cmd_taken |=> status_one[1]; endproperty
   a_wel_set: assert property (p_wel_set) else $error("latch not set");
   property p_busy_len; $fell(status_one[0]) |-> busy_cnt == OP_CYCLES && !status_one[1]; endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length or latch wrong");
   property p_busy_refuse; cmd.valid && !rd_op ##1 status_one[0] |-> cmd_refused; endproperty
   a_busy_refuse: assert property (p_busy_refuse) else $error("command taken while busy");
   property p_pdown; cmd.valid && cmd.opcode != FWPS_OP_RELPD ##1 power_down |-> cmd_refused; endproperty
   a_pdown: assert property (p_pdown) else $error("command taken in power-down");
   property p_wp_block;
      (!wp_n_pin)[*4] ##0 (cmd.valid && cmd.opcode == FWPS_OP_WRSR && if_mode inside {FWPS_IF_SPI, FWPS_IF_DUAL})
      ##1 status_one[7] |-> cmd_refused;
   endproperty
   a_wp_block: assert property (p_wp_block) else $error("status write taken with pin low");
   property p_lock; cmd.valid && cmd.opcode == FWPS_OP_WRSR ##1 status_two[0] |-> cmd_refused; endproperty
   a_lock: assert property (p_lock) else $error("status write taken while locked");
endmodule : fwps_core_chk

bind fwps_core fwps_core_chk #(.TPU_CYCLES(TPU_CYCLES), .OP_CYCLES(OP_CYCLES)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .wp_n_pin(wp_n_pin), .cmd(cmd), .if_mode(if_mode),
   .status_one(status_one), .status_two(status_two), .cmd_taken(cmd_taken),
   .cmd_refused(cmd_refused), .power_down(power_down));

// ---- sim/fwps_host.sv ----
/* host model: frames each instruction with a serial clock burst,
   then hands it over as one cmd pulse. assumes 50 MHz ref_clk. */
`timescale 1ns/1ns
module fwps_host
   import fwps_pkg::*;
(
   // clock
   input  wire logic       ref_clk,
   // to the device
   output fwps_cmd_t       cmd,
   output logic            sclk_pin,
   // answers
   input  wire logic       cmd_taken,
   input  wire logic       cmd_refused,
   input  wire logic       array_write_go
);
   initial begin
      cmd = '0;
      sclk_pin = 1'b0;
   end
   // serial clock idles low between frames; released fields are inverted
   task automatic send(input logic [7:0] op, input logic [7:0] d1, input logic [7:0] d2,
                       output logic tk, output logic rf, output logic go);
      #7;
      repeat (2) begin
         #80 sclk_pin = 1'b1;
         #80 sclk_pin = 1'b0;
      end
      @(negedge ref_clk);
      cmd = '{valid: 1'b1, opcode: op, data1: d1, data2: d2};
      // answer stands one cycle only: take it before the release
      @(negedge ref_clk);
      tk = cmd_taken;
      rf = cmd_refused;
      go = array_write_go;
      cmd = '{valid: 1'b0, opcode: ~op, data1: ~d1, data2: ~d2};
      @(negedge ref_clk);
   endtask : send
endmodule : fwps_host

// ---- sim/test_flash_write_protect_status.sv ----
/* self-checking bench of fwps_core driven through the host model.
   assumes fwps_pkg, fwps_core, fwps_host and the bound checker. */
`timescale 1ns/1ns
module test_flash_write_protect_status
   import fwps_pkg::*;
   ;
   logic         ref_clk, rst, wp_n_pin, sclk_pin, tk, rf, go;
   fwps_cmd_t    cmd;
   fwps_ifmode_t if_mode;
   logic [7:0]   status_one, status_two;
   logic         cmd_taken, cmd_refused, array_write_go, array_write_top, power_down, otp_locked, sclk_rise;
   int           fail_count, checked, rise_count;

   fwps_core #(.TPU_CYCLES(50), .OP_CYCLES(64)) dut (
      .ref_clk(ref_clk), .rst(rst), .wp_n_pin(wp_n_pin), .sclk_pin(sclk_pin), .cmd(cmd),
      .if_mode(if_mode), .status_one(status_one), .status_two(status_two), .cmd_taken(cmd_taken),
      .cmd_refused(cmd_refused), .array_write_go(array_write_go), .array_write_top(array_write_top),
      .power_down(power_down), .otp_locked(otp_locked), .sclk_rise(sclk_rise));
   fwps_host u_host (.ref_clk(ref_clk), .cmd(cmd), .sclk_pin(sclk_pin), .cmd_taken(cmd_taken),
      .cmd_refused(cmd_refused), .array_write_go(array_write_go));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // serial clock rising edges seen by the device
   always @(posedge ref_clk) begin
      if (sclk_rise === 1'b1)
         rise_count++;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic report_and_stop();
      $display("checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : chk
   // one instruction, then its answer; status settles one cycle later
   task automatic op(input logic [7:0] code, input logic [7:0] d1, input logic [7:0] d2, input logic exp_tk);
      int rises;
      rises = rise_count;
      u_host.send(code, d1, d2, tk, rf, go);
      chk("answer", {6'h00, exp_tk, ~exp_tk}, {6'h00, tk, rf});
      chk("sclk_rise", 8'h02, 8'(rise_count - rises));
      @(negedge ref_clk);
   endtask : op
   task automatic settle();
      int n;
      n = 0;
      while (status_one[0] !== 1'b0 && n < 200) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 200) begin
         fail_count++;
         $display("unexpected busy: expected 0, seen 1");
         report_and_stop();
      end
   endtask : settle
   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      rst = 1'b1;
      wp_n_pin = 1'b1;
      if_mode = FWPS_IF_SPI;
      fail_count = 0;
      checked = 0;
      repeat (16) @(negedge ref_clk);
      rst = 1'b0;
      chk("status_one", 8'h00, status_one);
      chk("status_two", 8'h00, status_two);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b0);
      repeat (50) @(negedge ref_clk);
      op(FWPS_OP_PP, 8'h00, 8'h00, 1'b0);
      chk("go", 8'h00, {7'h00, go});
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      chk("status_one", 8'h02, status_one);
      op(FWPS_OP_WRDI, 8'h00, 8'h00, 1'b1);
      chk("status_one", 8'h00, status_one);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_PP, 8'h00, 8'h00, 1'b1);
      chk("go", 8'h01, {7'h00, go});
      chk("status_one", 8'h03, status_one);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b0);
      op(FWPS_OP_RDSR1, 8'h00, 8'h00, 1'b1);
      settle();
      chk("status_one", 8'h00, status_one);
      wp_n_pin = 1'b0;
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_WRSR, 8'hC4, 8'h00, 1'b1);
      settle();
      chk("status_one", 8'hC4, status_one);
      chk("top", 8'h00, {7'h00, array_write_top});
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_PP, 8'h00, 8'h00, 1'b0);
      op(FWPS_OP_WRSR, 8'h80, 8'h00, 1'b0);
      if_mode = FWPS_IF_DUAL;
      op(FWPS_OP_WRSR, 8'h80, 8'h00, 1'b0);
      chk("status_one", 8'hC6, status_one);
      if_mode = FWPS_IF_QUAD;
      op(FWPS_OP_WRSR, 8'hC4, 8'h40, 1'b1);
      settle();
      chk("status_two", 8'h40, status_two);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_PP, 8'h00, 8'h00, 1'b1);
      settle();
      if_mode = FWPS_IF_SPI;
      wp_n_pin = 1'b1;
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_WRSR, 8'h81, 8'h00, 1'b1);
      settle();
      chk("status_two", 8'h01, status_two);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_WRSR, 8'h00, 8'h00, 1'b0);
      op(FWPS_OP_PDOWN, 8'h00, 8'h00, 1'b1);
      chk("power_down", 8'h01, {7'h00, power_down});
      op(FWPS_OP_WRDI, 8'h00, 8'h00, 1'b0);
      op(FWPS_OP_RELPD, 8'h00, 8'h00, 1'b1);
      chk("power_down", 8'h00, {7'h00, power_down});
      op(FWPS_OP_WRDI, 8'h00, 8'h00, 1'b1);
      rst = 1'b1;
      repeat (4) @(negedge ref_clk);
      rst = 1'b0;
      chk("status_two", 8'h00, status_two);
      repeat (50) @(negedge ref_clk);
      op(FWPS_OP_PFX_A, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_PFX_B, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_WREN, 8'h00, 8'h00, 1'b1);
      op(FWPS_OP_WRSR, 8'h01, 8'h00, 1'b1);
      settle();
      chk("otp", 8'h01, {7'h00, otp_locked});
      report_and_stop();
   end
endmodule : test_flash_write_protect_status
